// [logic/card_cmd_defs.vh]
`ifndef CARD_CMD_DEFS_VH
`define CARD_CMD_DEFS_VH
// card states
`define ST_IDLE 4'h0
`define ST_READY 4'h1
`define ST_IDENT 4'h2
`define ST_STBY 4'h3
`define ST_TRAN 4'h4
`define ST_DATA 4'h5
`define ST_RCV 4'h6
`define ST_PRG 4'h7
`define ST_DIS 4'h8
`define ST_INA 4'h9
// command indices
`define CMD_GO_IDLE 6'h00
`define CMD_OP_COND 6'h01
`define CMD_ALL_ID 6'h02
`define CMD_SET_ADDR 6'h03
`define CMD_SEL 6'h07
`define CMD_GET_CSD 6'h09
`define CMD_GET_ID 6'h0A
`define CMD_RD_STREAM 6'h0B
`define CMD_STOP 6'h0C
`define CMD_STATUS 6'h0D
`define CMD_INACTIVE 6'h0F
`define CMD_BLK_LEN 6'h10
`define CMD_RD_ONE 6'h11
`define CMD_RD_MULTI 6'h12
`define CMD_WR_STREAM 6'h14
// frame layout
`define FRAME_BITS 6'h30
`define LONG_BITS 8'h88
`define SHORT_BITS 8'h30
`define LONG_CODE 6'h3F
// status word fields
`define STAT_CRC_ERR 23
`define STAT_ILLEGAL 22
`define STAT_STATE_LSB 9
`define STAT_RDY_DATA 8
// reset values
`define RCA_RST 16'h0000
`define BLK_LEN_RST 32'h00000200
// timing, in link clock periods, and read buffer depth in entries
`define NCR_CLKS 4'h2
`define BUSY_CLKS 8'h08
`define FIFO_DEPTH 16
`endif

// [logic/cmd_crc7.v]
`timescale 1ns/10ps
module cmd_crc7 (
  input wire [39:0] msg,
  output reg [6:0] crc
);
  integer i;
  reg fb;
  always @* begin
    crc = 7'h00;
    fb = 1'b0;
    for (i = 39; i >= 0; i = i - 1) begin
      fb = msg[i] ^ crc[6];
      crc = {crc[5:0], 1'b0} ^ {3'h0, fb, 2'h0, fb};
    end
  end
endmodule

// [logic/data_fifo.v]
`timescale 1ns/10ps
module data_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire nrst,
  input wire flush,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0] wp_r;
  reg [AW:0] rp_r;
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rp_r[AW-1:0]];

  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// [logic/card_bus_command_decoder.v]
`timescale 1ns/10ps
`include "card_cmd_defs.vh"
module card_bus_command_decoder (
  input wire clk,
  input wire nrst,
  input wire bus_clk,
  input wire cmd_in,
  output reg cmd_out,
  output reg cmd_oe,
  input wire dat_in,
  output reg dat_out,
  output reg dat_oe,
  input wire [31:0] ocr,
  input wire [127:0] cid,
  input wire [127:0] csd,
  input wire [7:0] rd_data,
  input wire rd_valid,
  output wire rd_ready,
  output reg [7:0] wr_data,
  output reg wr_valid,
  output reg [31:0] xfer_addr,
  output reg xfer_rd,
  output reg xfer_wr,
  output reg xfer_stop,
  output reg [3:0] card_state,
  output reg [15:0] rca,
  output reg [31:0] blk_len
);
  // ----------------------------------------
  // link sampling
  // ----------------------------------------
  reg [2:0] clk_s_r;
  reg [1:0] cmd_s_r;
  reg [1:0] dat_s_r;
  wire rise = clk_s_r[1] && !clk_s_r[2];
  wire fall = !clk_s_r[1] && clk_s_r[2];
  wire cmd_bit = cmd_s_r[1];
  wire dat_bit = dat_s_r[1];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_s_r <= 3'h0;
      cmd_s_r <= 2'h3;
      dat_s_r <= 2'h3;
    end else begin
      clk_s_r <= {clk_s_r[1:0], bus_clk};
      cmd_s_r <= {cmd_s_r[0], cmd_in};
      dat_s_r <= {dat_s_r[0], dat_in};
    end
  end

  // ----------------------------------------
  // frame check
  // ----------------------------------------
  localparam DP_IDLE = 2'h0;
  localparam DP_START = 2'h1;
  localparam DP_BYTE = 2'h2;
  localparam DP_END = 2'h3;

  reg [47:0] rx_r;
  reg [5:0] rx_cnt_r;
  reg [135:0] tx_r;
  reg [7:0] tx_left_r;
  reg [3:0] ncr_r;
  reg [7:0] busy_r;
  reg crc_err_r;
  reg illegal_r;
  reg [1:0] dph_r;
  reg [7:0] dsr_r;
  reg [2:0] dbit_r;
  reg [31:0] dcnt_r;
  reg stream_r;
  reg multi_r;
  reg flush_r;

  wire [47:0] frame = {rx_r[46:0], cmd_bit};
  wire [5:0] idx = frame[45:40];
  wire [31:0] arg = frame[39:8];
  wire [6:0] rx_crc;
  wire [6:0] tx_crc;
  wire frame_done = rise && rx_cnt_r == `FRAME_BITS - 6'h01;
  wire frame_ok = !frame[47] && frame[46] && frame[0];
  wire crc_ok = rx_crc == frame[7:1];
  wire rca_hit = arg[31:16] == rca;
  wire resp_busy = tx_left_r != 8'h00;
  wire link_idle = !resp_busy && busy_r == 8'h00;

  reg [31:0] status;
  always @* begin
    status = 32'h00000000;
    status[`STAT_CRC_ERR] = crc_err_r;
    status[`STAT_ILLEGAL] = illegal_r;
    status[`STAT_STATE_LSB+3:`STAT_STATE_LSB] = card_state;
    status[`STAT_RDY_DATA] = card_state == `ST_TRAN;
  end

  cmd_crc7 u_rx_crc (
    .msg(frame[47:8]),
    .crc(rx_crc)
  );
  cmd_crc7 u_tx_crc (
    .msg({2'b00, idx, status}),
    .crc(tx_crc)
  );

  // ----------------------------------------
  // read data buffer
  // ----------------------------------------
  wire [7:0] f_data;
  wire f_valid;
  wire rd_run = card_state == `ST_DATA && link_idle;
  wire f_pop = fall && rd_run && dph_r == DP_BYTE && dbit_r == 3'h0;

  data_fifo #(
    .WIDTH(8),
    .DEPTH(`FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .flush(flush_r),
    .in_data(rd_data),
    .in_valid(rd_valid),
    .in_ready(rd_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // each accepted command picks the answer kind and the next state
  localparam RK_NONE = 2'h0;
  localparam RK_SHORT = 2'h1;
  localparam RK_LONG = 2'h2;
  localparam RK_OCR = 2'h3;

  reg [1:0] rk;
  reg [127:0] long_src;
  reg [3:0] nst;
  reg legal;
  reg go_rd;
  reg go_wr;
  reg stop;
  always @* begin
    rk = RK_NONE;
    long_src = cid;
    nst = card_state;
    legal = 1'b1;
    go_rd = 1'b0;
    go_wr = 1'b0;
    stop = 1'b0;
    case (idx)
      `CMD_GO_IDLE: begin
        nst = `ST_IDLE;
        stop = 1'b1;
      end
      `CMD_OP_COND: begin
        legal = card_state == `ST_IDLE;
        if (legal) begin
          rk = RK_OCR;
          nst = `ST_READY;
        end
      end
      `CMD_ALL_ID: begin
        legal = card_state == `ST_READY;
        if (legal) begin
          rk = RK_LONG;
          nst = `ST_IDENT;
        end
      end
      `CMD_SET_ADDR: begin
        legal = card_state == `ST_IDENT || card_state == `ST_STBY;
        if (legal) begin
          rk = RK_SHORT;
          nst = `ST_STBY;
        end
      end
      `CMD_SEL: begin
        if (rca_hit && arg[31:16] != 16'h0000) begin
          if (card_state == `ST_STBY) begin
            rk = RK_SHORT;
            nst = `ST_TRAN;
          end else if (card_state == `ST_DIS) begin
            rk = RK_SHORT;
            nst = `ST_PRG;
          end else begin
            legal = card_state == `ST_TRAN || card_state == `ST_DATA ||
              card_state == `ST_RCV || card_state == `ST_PRG;
          end
        end else begin
          if (card_state == `ST_TRAN || card_state == `ST_DATA ||
              card_state == `ST_RCV) begin
            nst = `ST_STBY;
            stop = 1'b1;
          end else if (card_state == `ST_PRG) begin
            nst = `ST_DIS;
          end
        end
      end
      `CMD_GET_CSD, `CMD_GET_ID: begin
        legal = card_state == `ST_STBY;
        if (legal && rca_hit) begin
          rk = RK_LONG;
          long_src = idx == `CMD_GET_CSD ? csd : cid;
        end
      end
      `CMD_RD_STREAM, `CMD_RD_ONE, `CMD_RD_MULTI: begin
        legal = card_state == `ST_TRAN ||
          (card_state == `ST_DATA && idx == `CMD_RD_MULTI);
        if (legal) begin
          rk = RK_SHORT;
          nst = `ST_DATA;
          go_rd = 1'b1;
        end
      end
      `CMD_STOP: begin
        legal = card_state == `ST_DATA || card_state == `ST_RCV;
        if (legal) begin
          rk = RK_SHORT;
          nst = card_state == `ST_RCV ? `ST_PRG : `ST_TRAN;
          stop = 1'b1;
        end
      end
      `CMD_STATUS: begin
        legal = card_state >= `ST_STBY && card_state <= `ST_DIS;
        if (legal && rca_hit) begin
          rk = RK_SHORT;
        end
      end
      `CMD_INACTIVE: begin
        legal = card_state >= `ST_STBY && card_state <= `ST_DIS;
        if (legal && rca_hit) begin
          nst = `ST_INA;
          stop = 1'b1;
        end
      end
      `CMD_BLK_LEN: begin
        legal = card_state == `ST_TRAN;
        if (legal) begin
          rk = RK_SHORT;
        end
      end
      `CMD_WR_STREAM: begin
        legal = card_state == `ST_TRAN;
        if (legal) begin
          rk = RK_SHORT;
          nst = `ST_RCV;
          go_wr = 1'b1;
        end
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // main sequencer
  // ----------------------------------------
  wire accept = frame_done && frame_ok && crc_ok && card_state != `ST_INA;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_r <= 48'h000000000000;
      rx_cnt_r <= 6'h00;
      tx_r <= {136{1'b1}};
      tx_left_r <= 8'h00;
      ncr_r <= 4'h0;
      busy_r <= 8'h00;
      crc_err_r <= 1'b0;
      illegal_r <= 1'b0;
      card_state <= `ST_IDLE;
      rca <= `RCA_RST;
      blk_len <= `BLK_LEN_RST;
      cmd_out <= 1'b1;
      cmd_oe <= 1'b0;
      dat_out <= 1'b1;
      dat_oe <= 1'b0;
      dph_r <= DP_IDLE;
      dsr_r <= 8'h00;
      dbit_r <= 3'h0;
      dcnt_r <= 32'h00000000;
      stream_r <= 1'b0;
      multi_r <= 1'b0;
      flush_r <= 1'b0;
      wr_data <= 8'h00;
      wr_valid <= 1'b0;
      xfer_addr <= 32'h00000000;
      xfer_rd <= 1'b0;
      xfer_wr <= 1'b0;
      xfer_stop <= 1'b0;
    end else begin
      wr_valid <= 1'b0;
      xfer_rd <= 1'b0;
      xfer_wr <= 1'b0;
      xfer_stop <= 1'b0;
      flush_r <= 1'b0;
      // receive: msb first, start bit opens a frame, only while quiet
      if (rise && !resp_busy) begin
        if (rx_cnt_r != 6'h00 || !cmd_bit) begin
          rx_r <= frame;
          rx_cnt_r <= frame_done ? 6'h00 : rx_cnt_r + 6'h01;
        end
      end
      if (frame_done && frame_ok && !crc_ok) begin
        crc_err_r <= 1'b1;
      end
      if (accept) begin
        card_state <= nst;
        if (!legal) begin
          illegal_r <= 1'b1;
        end
        if (rk != RK_NONE) begin
          ncr_r <= `NCR_CLKS;
          // flags clear once reported; a new error the same cycle wins
          if (rk == RK_SHORT) begin
            crc_err_r <= 1'b0;
            illegal_r <= !legal;
          end
        end
        case (rk)
          RK_SHORT: begin
            tx_r <= {2'b00, idx, status, tx_crc, 1'b1, 88'h0};
            tx_left_r <= `SHORT_BITS;
          end
          RK_OCR: begin
            tx_r <= {2'b00, `LONG_CODE, ocr, 7'h7F, 1'b1, 88'h0};
            tx_left_r <= `SHORT_BITS;
          end
          RK_LONG: begin
            tx_r <= {2'b00, `LONG_CODE, long_src[127:1], 1'b1};
            tx_left_r <= `LONG_BITS;
          end
          default: begin
            tx_left_r <= 8'h00;
          end
        endcase
        if (legal && idx == `CMD_SET_ADDR) begin
          rca <= arg[31:16];
        end
        if (legal && idx == `CMD_BLK_LEN) begin
          blk_len <= arg;
        end
        if (stop) begin
          dph_r <= DP_IDLE;
          dat_oe <= 1'b0;
          dat_out <= 1'b1;
          flush_r <= 1'b1;
          xfer_stop <= 1'b1;
          if (idx == `CMD_STOP && card_state == `ST_RCV) begin
            busy_r <= `BUSY_CLKS;
          end
        end
        if (go_rd || go_wr) begin
          xfer_addr <= arg;
          xfer_rd <= go_rd;
          xfer_wr <= go_wr;
          stream_r <= idx == `CMD_RD_STREAM;
          multi_r <= idx == `CMD_RD_MULTI;
          dph_r <= go_rd ? DP_START : DP_IDLE;
          dcnt_r <= 32'h00000000;
          dbit_r <= 3'h0;
          dat_oe <= 1'b0;
          flush_r <= go_rd;
        end
      end
      // response: wait the turnaround, then shift out msb first
      if (fall && resp_busy) begin
        if (ncr_r != 4'h0) begin
          ncr_r <= ncr_r - 4'h1;
        end else begin
          cmd_oe <= 1'b1;
          cmd_out <= tx_r[135];
          tx_r <= {tx_r[134:0], 1'b1};
          tx_left_r <= tx_left_r - 8'h01;
        end
      end else if (fall) begin
        cmd_oe <= 1'b0;
        cmd_out <= 1'b1;
      end
      // busy after a stopped write, then back to transfer
      if (fall && !resp_busy && busy_r != 8'h00) begin
        dat_oe <= 1'b1;
        dat_out <= 1'b0;
        busy_r <= busy_r - 8'h01;
      end else if (fall && !resp_busy && card_state == `ST_PRG && !accept) begin
        dat_oe <= 1'b0;
        dat_out <= 1'b1;
        card_state <= `ST_TRAN;
      end
      // read data: start bit, bytes msb first, end bit per block
      if (fall && rd_run && !accept) begin
        case (dph_r)
          DP_START: begin
            dat_oe <= 1'b1;
            dat_out <= 1'b0;
            dph_r <= DP_BYTE;
            dbit_r <= 3'h0;
          end
          DP_BYTE: begin
            // an empty buffer stalls the line high mid-block
            if (dbit_r == 3'h0) begin
              dat_out <= f_valid ? f_data[7] : 1'b1;
              if (f_valid) begin
                dsr_r <= {f_data[6:0], 1'b0};
                dbit_r <= 3'h1;
              end
            end else begin
              dat_out <= dsr_r[7];
              dsr_r <= {dsr_r[6:0], 1'b0};
              dbit_r <= dbit_r + 3'h1;
              if (dbit_r == 3'h7) begin
                dcnt_r <= dcnt_r + 32'h00000001;
                if (!stream_r && dcnt_r + 32'h00000001 == blk_len) begin
                  dph_r <= DP_END;
                end
              end
            end
          end
          DP_END: begin
            dat_out <= 1'b1;
            dcnt_r <= 32'h00000000;
            if (multi_r) begin
              dph_r <= DP_START;
            end else begin
              dph_r <= DP_IDLE;
              card_state <= `ST_TRAN;
            end
          end
          default: begin
            dat_oe <= 1'b0;
          end
        endcase
      end
      // a finished single block lets go of the line one period after its end bit
      if (fall && card_state == `ST_TRAN && !accept) begin
        dat_oe <= 1'b0;
        dat_out <= 1'b1;
      end
      // write stream: wait for start bit, assemble bytes
      if (rise && card_state == `ST_RCV && !resp_busy && !accept) begin
        if (dph_r == DP_IDLE) begin
          if (!dat_bit) begin
            dph_r <= DP_BYTE;
            dbit_r <= 3'h0;
          end
        end else begin
          dsr_r <= {dsr_r[6:0], dat_bit};
          dbit_r <= dbit_r + 3'h1;
          if (dbit_r == 3'h7) begin
            wr_data <= {dsr_r[6:0], dat_bit};
            wr_valid <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// [bench/card_bus_command_decoder_properties.sv]
`timescale 1ns/10ps
`include "card_cmd_defs.vh"
module card_bus_command_decoder_properties (
  input wire clk,
  input wire nrst,
  input wire bus_clk,
  input wire cmd_in,
  input wire cmd_out,
  input wire cmd_oe,
  input wire dat_in,
  input wire dat_out,
  input wire dat_oe,
  input wire [31:0] ocr,
  input wire [127:0] cid,
  input wire [127:0] csd,
  input wire [7:0] rd_data,
  input wire rd_valid,
  input wire rd_ready,
  input wire [7:0] wr_data,
  input wire wr_valid,
  input wire [31:0] xfer_addr,
  input wire xfer_rd,
  input wire xfer_wr,
  input wire xfer_stop,
  input wire [3:0] card_state,
  input wire [15:0] rca,
  input wire [31:0] blk_len
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----
  // answer length in clk cycles
  // ----
  // 12.5 clk per link bit at the bench rate; a bit of slack for sync jitter
  reg [10:0] oe_cnt_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      oe_cnt_r <= 11'h000;
    else
      oe_cnt_r <= cmd_oe ? oe_cnt_r + 11'h001 : 11'h000;
  end
  chk_answer_len: assert property ($fell(cmd_oe) |-> oe_cnt_r inside {[590:610], [1690:1710]})
    else $error("answer length off");
  chk_idle_quiet: assert property (card_state == `ST_IDLE |-> !cmd_oe)
    else $error("answer in idle");
  chk_ina_quiet: assert property (card_state == `ST_INA |-> !cmd_oe && !dat_oe)
    else $error("inactive card drives");
  chk_rca_take: assert property ($changed(rca) |-> card_state == `ST_STBY)
    else $error("address changed outside stand-by");
  chk_len_take: assert property ($changed(blk_len) |-> card_state == `ST_TRAN)
    else $error("block length changed outside transfer");
  chk_rd_start: assert property (xfer_rd |-> card_state == `ST_DATA)
    else $error("read start without data state");
  chk_wr_byte: assert property (xfer_wr || wr_valid |-> card_state == `ST_RCV)
    else $error("write byte outside receive");
  chk_stop_end: assert property (xfer_stop |-> !dat_oe && !(card_state inside {`ST_DATA, `ST_RCV}))
    else $error("stop left a transfer running");
  chk_sel_own: assert property ($changed(card_state) && card_state == `ST_TRAN
    && $past(card_state) == `ST_STBY |-> rca != 16'h0000)
    else $error("selected with zero address");
  chk_desel_quiet: assert property ($changed(card_state) && card_state == `ST_STBY
    && $past(card_state) == `ST_TRAN |-> ##50 !cmd_oe)
    else $error("deselect answered");
  chk_dat_start: assert property ($rose(dat_oe) |-> card_state inside {`ST_DATA, `ST_PRG})
    else $error("data line driven out of turn");
  cover property (xfer_rd);
  cover property (xfer_wr);
  cover property (xfer_stop);
  cover property (card_state == `ST_INA);
endmodule
bind card_bus_command_decoder card_bus_command_decoder_properties chk (.clk(clk), .nrst(nrst),
  .bus_clk(bus_clk), .cmd_in(cmd_in), .cmd_out(cmd_out), .cmd_oe(cmd_oe), .dat_in(dat_in),
  .dat_out(dat_out), .dat_oe(dat_oe), .ocr(ocr), .cid(cid), .csd(csd), .rd_data(rd_data),
  .rd_valid(rd_valid), .rd_ready(rd_ready), .wr_data(wr_data), .wr_valid(wr_valid),
  .xfer_addr(xfer_addr), .xfer_rd(xfer_rd), .xfer_wr(xfer_wr), .xfer_stop(xfer_stop),
  .card_state(card_state), .rca(rca), .blk_len(blk_len));

// [bench/card_host_model.sv]
`timescale 1ns/10ps
module card_host_model (
  output reg bus_clk,
  output wire cmd_in,
  input wire cmd_out,
  input wire cmd_oe,
  output wire dat_in,
  input wire dat_out,
  input wire dat_oe
);
  reg cmd_r = 1'h1;
  reg cmd_en_r = 1'h0;
  reg dat_r = 1'h1;
  reg dat_en_r = 1'h0;
  reg c_s = 1'h1;
  reg d_s = 1'h1;
  initial bus_clk = 1'h0;
  // ----
  // wires with pull-ups
  // ----
  assign cmd_in = cmd_oe ? cmd_out : (cmd_en_r ? cmd_r : 1'h1);
  assign dat_in = dat_oe ? dat_out : (dat_en_r ? dat_r : 1'h1);
  // clock only moves while a host task ticks it, idle periods included; lines sampled on the rise
  task tick;
    begin
      #62.5 bus_clk = 1'h1;
      c_s = cmd_in;
      d_s = dat_in;
      #62.5 bus_clk = 1'h0;
    end
  endtask
  function [6:0] crc7(input [39:0] m);
    integer i;
    begin
      crc7 = 7'h00;
      for (i = 39; i >= 0; i = i - 1)
        crc7 = {crc7[5:0], 1'h0} ^ ((m[i] ^ crc7[6]) ? 7'h09 : 7'h00);
    end
  endfunction
  task send(input [5:0] idx, input [31:0] arg, input bad);
    reg [47:0] f;
    integer i;
    begin
      f = {2'h1, idx, arg, crc7({2'h1, idx, arg}) ^ {6'h00, bad}, 1'h1};
      repeat (8) tick;
      cmd_en_r = 1'h1;
      for (i = 47; i >= 0; i = i - 1) begin
        cmd_r = f[i];
        tick;
      end
      cmd_en_r = 1'h0;
    end
  endtask
  task resp(input integer n, output reg [135:0] r, output reg got);
    integer i;
    begin
      r = 136'h0;
      got = 1'h0;
      for (i = 0; i < 64 && !got; i = i + 1) begin
        tick;
        got = !c_s;
      end
      for (i = 1; got && i < n; i = i + 1) begin
        tick;
        r = {r[134:0], c_s};
      end
    end
  endtask
  task dat_rx(input integer n, output reg [63:0] v, output reg got);
    integer i;
    begin
      v = 64'h0;
      got = 1'h0;
      for (i = 0; i < 64 && !got; i = i + 1) begin
        tick;
        got = !d_s;
      end
      for (i = 0; got && i < n; i = i + 1) begin
        tick;
        v = {v[62:0], d_s};
      end
    end
  endtask
  task dat_tx(input [15:0] b);
    integer i;
    begin
      dat_en_r = 1'h1;
      dat_r = 1'h0;
      tick;
      for (i = 15; i >= 0; i = i - 1) begin
        dat_r = b[i];
        tick;
      end
      dat_en_r = 1'h0;
    end
  endtask
  // host waits out busy before the next command
  task busy_len(output integer n);
    begin
      n = 0;
      repeat (24) begin
        tick;
        n = n + (d_s ? 0 : 1);
      end
    end
  endtask
endmodule

// [bench/card_bus_command_decoder_test.sv]
`timescale 1ns/10ps
`include "card_cmd_defs.vh"
module card_bus_command_decoder_test;
  reg clk;
  reg nrst;
  reg [7:0] rd_data = 8'h00;
  reg rd_valid = 1'h0;
  reg feed_arm = 1'h0;
  reg [31:0] ocr = 32'h80FF8000;
  reg [127:0] cid = 128'h0123456789ABCDEF0011223344556677;
  reg [127:0] csd = 128'hFEDCBA98765432100F1E2D3C4B5A6978;
  wire bus_clk;
  wire cmd_in;
  wire cmd_out;
  wire cmd_oe;
  wire dat_in;
  wire dat_out;
  wire dat_oe;
  wire rd_ready;
  wire [7:0] wr_data;
  wire wr_valid;
  wire [31:0] xfer_addr;
  wire xfer_rd;
  wire [3:0] card_state;
  wire [15:0] rca;
  wire [31:0] blk_len;
  reg [15:0] wr_log = 16'h0000;
  reg [135:0] r;
  reg got;
  reg [63:0] v;
  integer n;
  integer bad_count = 0;
  integer n_checks = 0;
  integer cycles = 0;
  card_bus_command_decoder dut (.clk(clk), .nrst(nrst), .bus_clk(bus_clk), .cmd_in(cmd_in),
    .cmd_out(cmd_out), .cmd_oe(cmd_oe), .dat_in(dat_in), .dat_out(dat_out), .dat_oe(dat_oe),
    .ocr(ocr), .cid(cid), .csd(csd), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .wr_data(wr_data), .wr_valid(wr_valid), .xfer_addr(xfer_addr),
    .xfer_rd(xfer_rd), .xfer_wr(), .xfer_stop(), .card_state(card_state), .rca(rca),
    .blk_len(blk_len));
  card_host_model host (.bus_clk(bus_clk), .cmd_in(cmd_in), .cmd_out(cmd_out),
    .cmd_oe(cmd_oe), .dat_in(dat_in), .dat_out(dat_out), .dat_oe(dat_oe));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ----
  // read source and write sink
  // ----
  // source starts one cycle after read start so the flush cannot eat the first byte
  always @(negedge clk) begin
    feed_arm <= xfer_rd;
    if (xfer_rd) begin
      rd_valid <= 1'h0;
      rd_data <= 8'hA0;
    end else if (feed_arm)
      rd_valid <= 1'h1;
    else if (rd_valid && rd_ready)
      rd_data <= rd_data + 8'h01;
  end
  always @(posedge clk) begin
    if (wr_valid)
      wr_log <= {wr_log[7:0], wr_data};
    cycles = cycles + 1;
    if (cycles == 80000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  // ----
  // checking helpers
  // ----
  task chk(input string what, input [135:0] seen, input [135:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cmd_short(input [5:0] idx, input [31:0] arg, input [3:0] st);
    begin
      host.send(idx, arg, 1'h0);
      host.resp(48, r, got);
      chk("short answer", {got, r[47:40], r[20:17], r[7:0]},
        {1'h1, 2'h0, idx, st, host.crc7(r[47:8]), 1'h1});
    end
  endtask
  task cmd_long(input [5:0] idx, input [31:0] arg, input [127:0] val);
    begin
      host.send(idx, arg, 1'h0);
      host.resp(136, r, got);
      chk("long answer", r, {2'h0, 6'h3F, val[127:1], 1'h1});
    end
  endtask
  task cmd_none(input [5:0] idx, input [31:0] arg, input bad);
    begin
      host.send(idx, arg, bad);
      host.resp(48, r, got);
      chk("silence", got, 1'h0);
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_ident;
    begin
      cmd_none(`CMD_GO_IDLE, 32'hFFFFFFFF, 1'h0);
      host.send(`CMD_OP_COND, 32'h00FF8000, 1'h0);
      host.resp(48, r, got);
      chk("op cond", r, {2'h0, 6'h3F, ocr, 8'hFF});
      cmd_long(`CMD_ALL_ID, 32'h0, cid);
      cmd_short(`CMD_SET_ADDR, 32'h1234ABCD, `ST_IDENT);
      chk("rca", {rca, card_state}, {16'h1234, `ST_STBY});
      cmd_none(`CMD_GET_CSD, 32'h12340000, 1'h1);
      cmd_none(6'h04, 32'h12340000, 1'h0);
      cmd_long(`CMD_GET_CSD, 32'h1234FFFF, csd);
      cmd_long(`CMD_GET_ID, 32'h12340000, cid);
      cmd_none(`CMD_STATUS, 32'h43210000, 1'h0);
      cmd_short(`CMD_STATUS, 32'h12340000, `ST_STBY);
      chk("error bits", r[31:30], 2'h3);
    end
  endtask
  task t_block;
    begin
      cmd_short(`CMD_SEL, 32'h12340000, `ST_STBY);
      chk("selected", card_state, `ST_TRAN);
      cmd_short(`CMD_BLK_LEN, 32'h00000004, `ST_TRAN);
      chk("block length", blk_len, 32'h00000004);
      cmd_short(`CMD_RD_ONE, 32'hFFFFFFF0, `ST_TRAN);
      chk("address", xfer_addr, 32'hFFFFFFF0);
      host.dat_rx(33, v, got);
      chk("block data", {got, v[32:0]}, {1'h1, 32'hA0A1A2A3, 1'h1});
      host.tick;
      chk("block done", card_state, `ST_TRAN);
      cmd_short(`CMD_RD_MULTI, 32'h00000040, `ST_TRAN);
      host.dat_rx(33, v, got);
      chk("first block", {got, v[32:0]}, {1'h1, 32'hA0A1A2A3, 1'h1});
      host.dat_rx(33, v, got);
      chk("next block", {got, v[32:0]}, {1'h1, 32'hA4A5A6A7, 1'h1});
      cmd_short(`CMD_STOP, 32'h0, `ST_DATA);
      chk("multi stopped", card_state, `ST_TRAN);
      cmd_none(`CMD_SEL, 32'h00000000, 1'h0);
      chk("deselected", card_state, `ST_STBY);
    end
  endtask
  task t_stream;
    begin
      cmd_short(`CMD_SEL, 32'h12340000, `ST_STBY);
      cmd_short(`CMD_RD_STREAM, 32'h00000100, `ST_TRAN);
      chk("buffer full", rd_ready, 1'h0);
      host.dat_rx(16, v, got);
      chk("stream data", {got, v[15:0]}, {1'h1, 16'hA0A1});
      cmd_short(`CMD_STOP, 32'h0, `ST_DATA);
      chk("stopped", card_state, `ST_TRAN);
      cmd_short(`CMD_WR_STREAM, 32'h00000200, `ST_TRAN);
      host.dat_tx(16'h5AC3);
      chk("write bytes", wr_log, 16'h5AC3);
      cmd_short(`CMD_STOP, 32'h0, `ST_RCV);
      host.busy_len(n);
      chk("busy span", n >= 7 && n <= 9, 1'h1);
      chk("after busy", card_state, `ST_TRAN);
      cmd_none(`CMD_INACTIVE, 32'h12340000, 1'h0);
      chk("inactive", card_state, `ST_INA);
      cmd_none(`CMD_STATUS, 32'h12340000, 1'h0);
    end
  endtask
  task tally_and_finish;
    begin
      if (bad_count == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    nrst = 1'h0;
    repeat (4) @(negedge clk);
    nrst = 1'h1;
    repeat (4) @(negedge clk);
    t_ident;
    t_block;
    t_stream;
    tally_and_finish;
  end
endmodule
